//--- common/hht_pkg.sv
// Purpose: Shared constants for the host handshake and trigger block
// Assumes: 50 MHz sys_clk, 32-bit register bus, 16-bit host data pins
// Notes: Byte offsets are word aligned

package hht_pkg;
	// Register byte offsets
	localparam logic [3:0] HHT_OFS_CONFIG1 = 4'h0;
	localparam logic [3:0] HHT_OFS_MODE = 4'h4;
	localparam logic [3:0] HHT_OFS_STATUS = 4'h8;
	localparam logic [3:0] HHT_OFS_CONTROL = 4'hc;
	// Configuration register 1 fields
	localparam int HHT_CFG_SSF_BIT = 8;
	localparam int HHT_CFG_EXT_EN_BIT = 7;
	localparam int HHT_CFG_ZWAIT_BIT = 0;
	localparam logic [15:0] HHT_CFG1_RESET = 16'h0000;
	// Mode register fields
	localparam int HHT_MODE_LSB = 0;
	localparam int HHT_MODE_WTG_BIT = 4;
	// Status word fields
	localparam int HHT_ST_STRAP_BIT = 0;
	localparam int HHT_ST_SSF_BIT = 1;
	localparam int HHT_ST_BC_RUN_BIT = 2;
	localparam int HHT_ST_WTG_BIT = 3;
	localparam int HHT_ST_MON_BIT = 4;
	localparam int HHT_ST_BUSY_BIT = 5;
	localparam int HHT_ST_CNT_LSB = 8;
	// Control register fields
	localparam int HHT_CTL_BC_CLR_BIT = 0;
	localparam int HHT_CTL_MON_CLR_BIT = 1;
	// Internal transfer length of one host access
	localparam logic [1:0] HHT_XFER_CYCLES = 2'h2;
	localparam logic [7:0] HHT_CNT_RESET = 8'h00;

	typedef enum logic [2:0]
	{
		HHT_MODE_RT = 3'h0,
		HHT_MODE_BC = 3'h1,
		HHT_MODE_BC_ENH = 3'h2,
		HHT_MODE_WMON = 3'h3,
		HHT_MODE_MMON = 3'h4
	} hht_mode_t;

	typedef enum logic [1:0]
	{
		HHT_IDLE = 2'b00,
		HHT_XFER = 2'b01,
		HHT_HOLD = 2'b11
	} hht_state_t;
endpackage

//--- common/hht_trig_if.sv
// Purpose: Carries the synchronised trigger pulse and flag level between modules
// Assumes: Both ends on sys_clk
// Notes: trig_pulse lasts one cycle per rising edge

`timescale 1ns/1ps
`default_nettype none

interface hht_trig_if;
	logic trig_pulse;
	logic subsystem_flag_in_low;
	modport src (output trig_pulse, output subsystem_flag_in_low);
	modport dst (input trig_pulse, input subsystem_flag_in_low);
endinterface

`default_nettype wire

//--- design/hht_trigger.sv
// Purpose: Synchronises the trigger and subsystem flag pins
// Assumes: Pins are asynchronous to sys_clk
// Notes: Edge detection compares the second flop with a third flop

`timescale 1ns/1ps
`default_nettype none

module hht_trigger
	import hht_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic external_trigger_in,
	input wire logic subsystem_flag_in,
	hht_trig_if.src tif
);
	logic trig_s1;
	logic trig_s2;
	logic trig_q;
	logic ssf_s1;
	logic ssf_s2;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trig_s1 <= 1'b0;
			trig_s2 <= 1'b0;
			trig_q <= 1'b0;
		end
		else
		begin
			trig_s1 <= external_trigger_in;
			trig_s2 <= trig_s1;
			trig_q <= trig_s2;
		end
	end

	// Flag idles high so reset to the inactive level
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ssf_s1 <= 1'b1;
			ssf_s2 <= 1'b1;
		end
		else
		begin
			ssf_s1 <= subsystem_flag_in;
			ssf_s2 <= ssf_s1;
		end
	end

	assign tif.trig_pulse = trig_s2 & ~trig_q; // [RQ17]
	assign tif.subsystem_flag_in_low = ~ssf_s2;

	a_trig_single: assert property ( // [RQ17]
		@(posedge sys_clk) disable iff (!rst_n)
		tif.trig_pulse |=> !tif.trig_pulse)
		else $error("trigger pulse longer than one cycle");

	a_trig_edge: assert property ( // [RQ17]
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(trig_s2) |-> tif.trig_pulse)
		else $error("rising trigger edge produced no pulse");
endmodule

`default_nettype wire

//--- design/hht_host_port.sv
// Purpose: Host handshake, buffer enable, strap and trigger dispatch
// Assumes: Host keeps address, direction and data stable while strobing
// Notes: Host pins pass two flops; one Avalon wait state per access
//
// What this block does
// RQ1 - In RT mode a low subsystem flag input sets the RT status flag bit.
// RQ2 - Config bit 8 reads back what software wrote, whatever the input.
// RQ3 - In plain BC mode with bit 7 set, a trigger edge starts the frame.
// RQ4 - In enhanced BC mode a wait-for-trigger op stalls until an edge.
// RQ5 - In word monitor mode with bit 7 set, a trigger edge starts it.
// RQ6 - In message monitor mode the trigger input is ignored.
// RQ7 - The strap selects buffered at 0 and transparent/DMA at 1.
// RQ8 - A nonzero-wait read ends with ready low and read data valid.
// RQ9 - A nonzero-wait write ends with ready low once the word is stored.
// RQ10 - The host keeps its strobe low until it sees ready low.
// RQ11 - In zero-wait mode ready stays high while idle.
// RQ12 - In zero-wait mode ready is low exactly during the internal access.
// RQ13 - In zero-wait mode the host waits for ready high before a new cycle.
// RQ14 - Buffer enable is low while an internal access is in progress.
// RQ15 - External logic may use low buffer enable to open its buffers.
// RQ16 - The host drives mem/reg high for memory and low for registers.
// RQ17 - The trigger pin is synchronised and each rising edge gives a pulse.

`timescale 1ns/1ps
`default_nettype none

module hht_host_port
	import hht_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic host_strobe_n,
	input wire logic host_rd_wr,
	input wire logic host_mem_reg,
	input wire logic [3:0] host_addr,
	input wire logic [15:0] host_data_in,
	output logic [15:0] host_data_out,
	output logic host_data_oe_n,
	output logic host_ready_n,
	output logic io_buffer_enable_n,
	input wire logic transparent_strap_in,
	input wire logic subsystem_flag_in,
	input wire logic external_trigger_in,
	output logic rt_status_subsys_flag,
	output logic bc_frame_start,
	output logic wtg_advance,
	output logic monitor_start
);
	logic rst_s1;
	logic rst_n;
	logic [23:0] pin_s1;
	logic [23:0] pin_s2;
	logic strobe_s_n;
	logic rd_s;
	logic mem_s;
	logic [3:0] addr_s;
	logic [15:0] din_s;
	logic strap_loaded;
	logic [1:0] strap_wait;
	logic transparent;
	logic [15:0] cfg1;
	hht_mode_t mode;
	logic bc_running;
	logic wtg_waiting;
	logic mon_active;
	logic [7:0] instr_cnt;
	logic ack;
	logic bus_wr;
	logic sw_wtg_set;
	logic sw_bc_clr;
	logic sw_mon_clr;
	hht_state_t state;
	hht_state_t next_state;
	logic [1:0] xfer_cnt;
	logic acc_rd;
	logic acc_mem;
	logic acc_zw;
	logic [3:0] acc_addr;
	logic [15:0] acc_data;
	logic [15:0] ram [16];
	logic zero_wait;
	logic host_cfg_wr;
	logic [15:0] status;
	logic trig_bc;
	logic trig_wtg;
	logic trig_mon;

	hht_trig_if tif ();

	hht_trigger u_trigger
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.external_trigger_in(external_trigger_in),
		.subsystem_flag_in(subsystem_flag_in),
		.tif(tif)
	);

	// Reset enters asynchronously but is released on the clock
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// Host pins are sampled as one bundle so fields stay aligned in time
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1 <= 24'hffffff;
			pin_s2 <= 24'hffffff;
		end
		else
		begin
			pin_s1 <= {transparent_strap_in, host_strobe_n, host_rd_wr,
				host_mem_reg, host_addr, host_data_in};
			pin_s2 <= pin_s1;
		end
	end

	assign strobe_s_n = pin_s2[22];
	assign rd_s = pin_s2[21];
	assign mem_s = pin_s2[20];
	assign addr_s = pin_s2[19:16];
	assign din_s = pin_s2[15:0];

	// Strap is caught once, after the pin flops have flushed their reset
	// value; catching earlier would always read transparent
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strap_wait <= 2'b00;
			strap_loaded <= 1'b0;
			transparent <= 1'b0;
		end
		else if (!strap_loaded)
		begin
			strap_wait <= {strap_wait[0], 1'b1};
			strap_loaded <= strap_wait[1];
			transparent <= pin_s2[23]; // [RQ7]
		end
	end

	// Zero-wait timing only exists on the buffered port
	assign zero_wait = cfg1[HHT_CFG_ZWAIT_BIT] & ~transparent; // [RQ7]

	function automatic logic [15:0] status_word(input logic busy);
		logic [15:0] w;
		w = 16'h0000;
		w[HHT_ST_STRAP_BIT] = transparent;
		w[HHT_ST_SSF_BIT] = rt_status_subsys_flag;
		w[HHT_ST_BC_RUN_BIT] = bc_running;
		w[HHT_ST_WTG_BIT] = wtg_waiting;
		w[HHT_ST_MON_BIT] = mon_active;
		w[HHT_ST_BUSY_BIT] = busy;
		w[HHT_ST_CNT_LSB +: 8] = instr_cnt;
		return w;
	endfunction

	// Procedural so that the flags read inside the function wake it up
	always_comb
	begin
		status = status_word(state != HHT_IDLE);
	end

	// Avalon slave: one wait state, then the access completes
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;
	assign bus_wr = avs_write & ack;
	assign sw_wtg_set = bus_wr && avs_address == HHT_OFS_MODE
		&& avs_writedata[HHT_MODE_WTG_BIT];
	assign sw_bc_clr = bus_wr && avs_address == HHT_OFS_CONTROL
		&& avs_writedata[HHT_CTL_BC_CLR_BIT];
	assign sw_mon_clr = bus_wr && avs_address == HHT_OFS_CONTROL
		&& avs_writedata[HHT_CTL_MON_CLR_BIT];

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			ack <= 1'b0;
		else
			ack <= (avs_read | avs_write) & ~ack;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			avs_readdata <= 32'h00000000;
		else if (avs_read && !ack)
		begin
			if (avs_address == HHT_OFS_CONFIG1)
				avs_readdata <= {16'h0000, cfg1}; // [RQ2]
			else if (avs_address == HHT_OFS_MODE)
				avs_readdata <= {29'h00000000, mode};
			else if (avs_address == HHT_OFS_STATUS)
				avs_readdata <= {16'h0000, status};
			else
				avs_readdata <= 32'h00000000;
		end
	end

	// Only software writes reach this register, never the flag pin
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cfg1 <= HHT_CFG1_RESET;
		else if (bus_wr && avs_address == HHT_OFS_CONFIG1)
			cfg1 <= avs_writedata[15:0]; // [RQ2]
		else if (host_cfg_wr)
			cfg1 <= acc_data; // [RQ2]
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			mode <= HHT_MODE_RT;
		else if (bus_wr && avs_address == HHT_OFS_MODE)
			mode <= hht_mode_t'(avs_writedata[HHT_MODE_LSB +: 3]);
	end

	// RT status flag follows the pin, not the configuration bit
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rt_status_subsys_flag <= 1'b0;
		else
			rt_status_subsys_flag <= (mode == HHT_MODE_RT)
				& tif.subsystem_flag_in_low; // [RQ1]
	end

	// Trigger dispatch; message monitor has no term here at all
	assign trig_bc = tif.trig_pulse && mode == HHT_MODE_BC
		&& cfg1[HHT_CFG_EXT_EN_BIT]; // [RQ3] [RQ6]
	assign trig_wtg = tif.trig_pulse && mode == HHT_MODE_BC_ENH
		&& wtg_waiting; // [RQ4] [RQ6]
	assign trig_mon = tif.trig_pulse && mode == HHT_MODE_WMON
		&& cfg1[HHT_CFG_EXT_EN_BIT]; // [RQ5] [RQ6]

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bc_frame_start <= 1'b0;
			wtg_advance <= 1'b0;
			monitor_start <= 1'b0;
		end
		else
		begin
			bc_frame_start <= trig_bc; // [RQ3]
			wtg_advance <= trig_wtg; // [RQ4]
			monitor_start <= trig_mon; // [RQ5]
		end
	end

	// Start events win over a software clear in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			bc_running <= 1'b0;
		else if (trig_bc)
			bc_running <= 1'b1; // [RQ3]
		else if (sw_bc_clr)
			bc_running <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			mon_active <= 1'b0;
		else if (trig_mon)
			mon_active <= 1'b1; // [RQ5]
		else if (sw_mon_clr)
			mon_active <= 1'b0;
	end

	// The trigger consumes a pending wait before a fresh one is armed
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wtg_waiting <= 1'b0;
			instr_cnt <= HHT_CNT_RESET;
		end
		else if (trig_wtg)
		begin
			wtg_waiting <= 1'b0; // [RQ4]
			instr_cnt <= instr_cnt + 8'h01;
		end
		// The arming write also sets the mode, so judge the written mode
		else if (sw_wtg_set
			&& avs_writedata[HHT_MODE_LSB +: 3] == HHT_MODE_BC_ENH)
			wtg_waiting <= 1'b1;
	end

	// Host access sequencer
	always_comb
	begin
		next_state = state;
		case (state)
			HHT_IDLE:
				if (!strobe_s_n)
					next_state = HHT_XFER;
			HHT_XFER:
				if (xfer_cnt == 2'h0)
					next_state = HHT_HOLD;
			HHT_HOLD:
				if (strobe_s_n)
					next_state = HHT_IDLE; // [RQ10]
			default:
				next_state = HHT_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= HHT_IDLE;
		else
			state <= next_state;
	end

	// Address, direction and data are held for the whole access
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			xfer_cnt <= 2'h0;
			acc_rd <= 1'b0;
			acc_mem <= 1'b0;
			acc_zw <= 1'b0;
			acc_addr <= 4'h0;
			acc_data <= 16'h0000;
		end
		else if (state == HHT_IDLE && !strobe_s_n)
		begin
			xfer_cnt <= HHT_XFER_CYCLES - 2'h1;
			acc_rd <= rd_s;
			acc_mem <= mem_s; // [RQ16]
			acc_zw <= zero_wait;
			acc_addr <= addr_s;
			acc_data <= din_s;
		end
		else if (state == HHT_XFER && xfer_cnt != 2'h0)
			xfer_cnt <= xfer_cnt - 2'h1;
	end

	assign host_cfg_wr = state == HHT_XFER && xfer_cnt == 2'h0 && !acc_rd
		&& !acc_mem && acc_addr == 4'h0;

	// Shared RAM has no reset; contents are undefined until written
	always_ff @(posedge sys_clk)
	begin
		if (state == HHT_XFER && xfer_cnt == 2'h0 && !acc_rd && acc_mem)
			ram[acc_addr] <= acc_data; // [RQ9]
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			host_data_out <= 16'h0000;
		else if (state == HHT_XFER && xfer_cnt == 2'h0 && acc_rd)
		begin
			if (acc_mem)
				host_data_out <= ram[acc_addr]; // [RQ8]
			else if (acc_addr == 4'h0)
				host_data_out <= cfg1;
			else
				host_data_out <= status;
		end
	end

	// Ready: low during the transfer for zero wait, else after it
	assign host_ready_n = acc_zw ? (state != HHT_XFER) // [RQ11] [RQ12]
		: (state != HHT_HOLD); // [RQ8] [RQ9]
	assign io_buffer_enable_n = (state != HHT_XFER); // [RQ14] [RQ15]
	assign host_data_oe_n = !(state == HHT_HOLD && acc_rd && !strobe_s_n);

	a_ssf_status_follow: assert property ( // [RQ1]
		@(posedge sys_clk) disable iff (!rst_n)
		(mode == HHT_MODE_RT && tif.subsystem_flag_in_low && $stable(mode))
		|=> rt_status_subsys_flag)
		else $error("subsystem flag low did not set status flag");

	a_cfg_bit_stable: assert property ( // [RQ2]
		@(posedge sys_clk) disable iff (!rst_n)
		(!bus_wr && !host_cfg_wr) |=> $stable(cfg1[HHT_CFG_SSF_BIT]))
		else $error("config subsystem bit changed without a write");

	a_bc_start_edge: assert property ( // [RQ3]
		@(posedge sys_clk) disable iff (!rst_n)
		(tif.trig_pulse && mode == HHT_MODE_BC && cfg1[HHT_CFG_EXT_EN_BIT])
		|=> bc_frame_start && bc_running)
		else $error("external start did not begin the frame");

	a_wtg_stall: assert property ( // [RQ4]
		@(posedge sys_clk) disable iff (!rst_n)
		(wtg_waiting && !tif.trig_pulse) |=> !wtg_advance && wtg_waiting)
		else $error("wait-for-trigger advanced without an edge");

	a_mon_start_edge: assert property ( // [RQ5]
		@(posedge sys_clk) disable iff (!rst_n)
		(tif.trig_pulse && mode == HHT_MODE_WMON && cfg1[HHT_CFG_EXT_EN_BIT])
		|=> monitor_start ##1 !monitor_start)
		else $error("word monitor start pulse wrong");

	a_msgmon_ignore: assert property ( // [RQ6]
		@(posedge sys_clk) disable iff (!rst_n)
		(mode == HHT_MODE_MMON) |-> !trig_bc && !trig_wtg && !trig_mon)
		else $error("trigger acted in message monitor mode");

	a_strap_fixed: assert property ( // [RQ7]
		@(posedge sys_clk) disable iff (!rst_n)
		strap_loaded |=> $stable(transparent))
		else $error("host interface mode changed after capture");

	a_ready_nonzero: assert property ( // [RQ8]
		@(posedge sys_clk) disable iff (!rst_n)
		(state == HHT_IDLE && !strobe_s_n && !zero_wait)
		|=> host_ready_n [*2] ##1 !host_ready_n)
		else $error("nonzero-wait ready not asserted after transfer");

	a_zw_idle_high: assert property ( // [RQ11]
		@(posedge sys_clk) disable iff (!rst_n)
		(state == HHT_IDLE) |-> host_ready_n)
		else $error("ready low while idle");

	a_zw_busy_low: assert property ( // [RQ12]
		@(posedge sys_clk) disable iff (!rst_n)
		(state == HHT_IDLE && !strobe_s_n && zero_wait)
		|=> !host_ready_n [*2] ##1 host_ready_n)
		else $error("zero-wait ready not low for the transfer");

	a_io_buffer_enable_n_access: assert property ( // [RQ14]
		@(posedge sys_clk) disable iff (!rst_n)
		(state == HHT_IDLE && !strobe_s_n)
		|=> !io_buffer_enable_n [*2] ##1 io_buffer_enable_n)
		else $error("buffer enable not low during access");
endmodule

`default_nettype wire

//--- bench/hht_host_model.sv
// Purpose: Host processor model for the strobe and ready handshake
// Assumes: Ready is sampled at rising edges of sys_clk
// Notes: Released data pins show the inverse of the last word

`timescale 1ns/1ps
`default_nettype none

module hht_host_model
(
	input wire logic sys_clk,
	input wire logic host_ready_n,
	input wire logic [15:0] host_data_out,
	output var logic host_strobe_n,
	output var logic host_rd_wr,
	output var logic host_mem_reg,
	output var logic [3:0] host_addr,
	output var logic [15:0] host_data_in
);
	initial
	begin
		host_strobe_n = 1'b1;
		host_rd_wr = 1'b1;
		host_mem_reg = 1'b0;
		host_addr = 4'h0;
		host_data_in = 16'h0000;
	end

	// Hold keeps the strobe low that many extra cycles after ready low
	task automatic access(input logic rd, input logic mem,
		input logic [3:0] a, input logic [15:0] wd, input int hold,
		output logic [15:0] q, output logic late);
		int n;
		begin
			n = 0;
			@(posedge sys_clk);
			host_rd_wr <= rd;
			host_mem_reg <= mem;
			host_addr <= a;
			host_data_in <= rd ? ~host_data_in : wd;
			host_strobe_n <= 1'b0;
			do
			begin
				@(posedge sys_clk);
				n++;
			end
			while (host_ready_n !== 1'b0 && n < 40);
			late = (n >= 40);
			q = host_data_out;
			repeat (hold) @(posedge sys_clk);
			host_strobe_n <= 1'b1;
			host_data_in <= ~host_data_in;
			n = 0;
			do
			begin
				@(posedge sys_clk);
				n++;
			end
			while (host_ready_n !== 1'b1 && n < 40);
			late = late | (n >= 40);
		end
	endtask
endmodule

`default_nettype wire

//--- bench/tb_hht_host_port.sv
// Purpose: Self-checking bench for the host handshake and trigger block
// Assumes: Host model stands in for the processor on the host pins
// Notes: Counters sample outputs on the falling edge, away from updates

`timescale 1ns/1ps
`default_nettype none

module tb_hht_host_port;
	import hht_pkg::*;
	logic sys_clk, reset_n, avs_read, avs_write, avs_waitrequest;
	logic [3:0] avs_address, host_addr;
	logic [31:0] avs_writedata, avs_readdata, rdq;
	logic host_strobe_n, host_rd_wr, host_mem_reg, host_data_oe_n;
	logic [15:0] host_data_in, host_data_out, hq;
	logic host_ready_n, io_buffer_enable_n, transparent_strap_in, late;
	logic subsystem_flag_in, external_trigger_in, rt_status_subsys_flag;
	logic bc_frame_start, wtg_advance, monitor_start;
	int n_mismatch, compares, n_io_buffer_enable_n, n_rdy, n_oe, n_bc, n_wtg, n_mon;
	int d_io_buffer_enable_n, d_rdy, d_oe;

	hht_host_port u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.host_strobe_n(host_strobe_n), .host_rd_wr(host_rd_wr),
		.host_mem_reg(host_mem_reg), .host_addr(host_addr),
		.host_data_in(host_data_in), .host_data_out(host_data_out),
		.host_data_oe_n(host_data_oe_n), .host_ready_n(host_ready_n),
		.io_buffer_enable_n(io_buffer_enable_n),
		.transparent_strap_in(transparent_strap_in),
		.subsystem_flag_in(subsystem_flag_in),
		.external_trigger_in(external_trigger_in),
		.rt_status_subsys_flag(rt_status_subsys_flag),
		.bc_frame_start(bc_frame_start), .wtg_advance(wtg_advance),
		.monitor_start(monitor_start));

	hht_host_model u_host (.sys_clk(sys_clk), .host_ready_n(host_ready_n),
		.host_data_out(host_data_out), .host_strobe_n(host_strobe_n),
		.host_rd_wr(host_rd_wr), .host_mem_reg(host_mem_reg),
		.host_addr(host_addr), .host_data_in(host_data_in));

	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	always @(negedge sys_clk)
	begin
		n_io_buffer_enable_n += (io_buffer_enable_n === 1'b0);
		n_rdy += (host_ready_n === 1'b0);
		n_oe += (host_data_oe_n === 1'b0);
		n_bc += (bc_frame_start === 1'b1);
		n_wtg += (wtg_advance === 1'b1);
		n_mon += (monitor_start === 1'b1);
	end

	task automatic conclude;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			$display("[FAIL] %0t word got %h exp %h", $time, got, exp);
			n_mismatch++;
		end
	endtask

	task automatic chk_cnt(input int got, input int exp);
		compares++;
		if (got != exp)
		begin
			$display("[FAIL] %0t count got %0d exp %0d", $time, got, exp);
			n_mismatch++;
		end
	endtask

	// Holds the request until waitrequest is sampled low
	task automatic av(input logic wr, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		begin
			n = 0;
			@(posedge sys_clk);
			avs_address <= a;
			avs_writedata <= d;
			avs_write <= wr;
			avs_read <= !wr;
			do
			begin
				@(posedge sys_clk);
				n++;
			end
			while (avs_waitrequest !== 1'b0 && n < 40);
			rdq = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			if (n >= 40)
			begin
				chk_cnt(n, 0);
				conclude();
			end
		end
	endtask

	task automatic hx(input logic rd, input logic mem, input logic [3:0] a,
		input logic [15:0] wd, input int hold);
		int b_i, b_r, b_o;
		begin
			b_i = n_io_buffer_enable_n;
			b_r = n_rdy;
			b_o = n_oe;
			u_host.access(rd, mem, a, wd, hold, hq, late);
			chk_word(32'(late), 32'h0);
			if (late)
				conclude();
			d_io_buffer_enable_n = n_io_buffer_enable_n - b_i;
			d_rdy = n_rdy - b_r;
			d_oe = n_oe - b_o;
		end
	endtask

	task automatic do_reset(input logic s);
		@(posedge sys_clk);
		reset_n <= 1'b0;
		transparent_strap_in <= s;
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic t_idle;
		chk_word(32'(host_ready_n), 32'h1);
		chk_word(32'(io_buffer_enable_n), 32'h1);
		av(1'b0, HHT_OFS_STATUS, 32'h0);
		chk_word(32'(rdq[HHT_ST_STRAP_BIT]), 32'h0);
		av(1'b1, 4'h6, 32'h0000_00ff);
		av(1'b0, 4'h6, 32'h0);
		chk_word(rdq, 32'h0);
		av(1'b0, HHT_OFS_CONFIG1, 32'h0);
		chk_word(rdq, 32'(HHT_CFG1_RESET));
	endtask

	task automatic t_host_nz;
		hx(1'b0, 1'b1, 4'h0, 16'h1234, 2);
		chk_cnt(d_io_buffer_enable_n, 2);
		chk_word(32'(d_rdy > 2), 32'h1);
		chk_cnt(d_oe, 0);
		hx(1'b0, 1'b0, 4'h0, 16'h0080, 0);
		hx(1'b1, 1'b1, 4'h0, 16'h0000, 0);
		chk_word(32'(hq), 32'h1234);
		chk_cnt(d_io_buffer_enable_n, 2);
		chk_word(32'(d_oe > 0), 32'h1);
		av(1'b0, HHT_OFS_CONFIG1, 32'h0);
		chk_word(rdq, 32'h0000_0080);
		av(1'b1, HHT_OFS_CONFIG1, 32'h0);
	endtask

	task automatic t_zero_wait(input logic s);
		av(1'b1, HHT_OFS_CONFIG1, 32'h1);
		hx(1'b0, 1'b1, 4'h3, 16'h5a5a, 5);
		if (s)
			chk_word(32'(d_rdy > 5), 32'h1);
		else
			chk_cnt(d_rdy, 2);
		chk_cnt(d_io_buffer_enable_n, 2);
		chk_word(32'(host_ready_n), 32'h1);
		av(1'b1, HHT_OFS_CONFIG1, 32'h0);
		hx(1'b1, 1'b1, 4'h3, 16'h0000, 0);
		chk_word(32'(hq), 32'h5a5a);
		av(1'b0, HHT_OFS_STATUS, 32'h0);
		chk_word(32'(rdq[HHT_ST_STRAP_BIT]), 32'(s));
	endtask

	task automatic t_ssf;
		av(1'b1, HHT_OFS_MODE, 32'(HHT_MODE_RT));
		av(1'b1, HHT_OFS_CONFIG1, 32'h0000_0100);
		subsystem_flag_in <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk_word(32'(rt_status_subsys_flag), 32'h1);
		av(1'b0, HHT_OFS_STATUS, 32'h0);
		chk_word(32'(rdq[HHT_ST_SSF_BIT]), 32'h1);
		av(1'b0, HHT_OFS_CONFIG1, 32'h0);
		chk_word(rdq, 32'h0000_0100);
		av(1'b1, HHT_OFS_CONFIG1, 32'h0);
		av(1'b0, HHT_OFS_CONFIG1, 32'h0);
		chk_word(rdq, 32'h0);
		subsystem_flag_in <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk_word(32'(rt_status_subsys_flag), 32'h0);
	endtask

	// One trigger edge held high long enough to show a single pulse
	task automatic t_trig(input logic [2:0] m, input logic en,
		input logic arm, input int eb, input int ew, input int em);
		int bb, bw, bm;
		begin
			av(1'b1, HHT_OFS_CONTROL, 32'h3);
			av(1'b1, HHT_OFS_CONFIG1, 32'(en) << HHT_CFG_EXT_EN_BIT);
			av(1'b1, HHT_OFS_MODE, 32'(m) | (32'(arm) << HHT_MODE_WTG_BIT));
			bb = n_bc;
			bw = n_wtg;
			bm = n_mon;
			repeat (10) @(posedge sys_clk);
			chk_cnt(n_bc + n_wtg + n_mon - bb - bw - bm, 0);
			av(1'b0, HHT_OFS_STATUS, 32'h0);
			chk_word(32'(rdq[HHT_ST_WTG_BIT]), 32'(arm));
			external_trigger_in <= 1'b1;
			repeat (8) @(posedge sys_clk);
			external_trigger_in <= 1'b0;
			repeat (6) @(posedge sys_clk);
			chk_cnt(n_bc - bb, eb);
			chk_cnt(n_wtg - bw, ew);
			chk_cnt(n_mon - bm, em);
			av(1'b0, HHT_OFS_STATUS, 32'h0);
			chk_word(32'(rdq[HHT_ST_BC_RUN_BIT]), 32'(eb));
			chk_word(32'(rdq[HHT_ST_MON_BIT]), 32'(em));
		end
	endtask

	initial
	begin
		repeat (40000) @(posedge sys_clk);
		chk_cnt(0, 1);
		conclude();
	end

	initial
	begin
		{reset_n, avs_read, avs_write} = 3'b000;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		transparent_strap_in = 1'b0;
		subsystem_flag_in = 1'b1;
		external_trigger_in = 1'b0;
		{n_mismatch, compares, n_io_buffer_enable_n, n_rdy, n_oe} = '0;
		{n_bc, n_wtg, n_mon} = '0;
		do_reset(1'b0);
		t_idle();
		t_host_nz();
		t_zero_wait(1'b0);
		t_ssf();
		t_trig(HHT_MODE_BC, 1'b1, 1'b0, 1, 0, 0);
		t_trig(HHT_MODE_BC, 1'b0, 1'b0, 0, 0, 0);
		t_trig(HHT_MODE_BC_ENH, 1'b0, 1'b1, 0, 1, 0);
		t_trig(HHT_MODE_BC_ENH, 1'b0, 1'b0, 0, 0, 0);
		t_trig(HHT_MODE_WMON, 1'b1, 1'b0, 0, 0, 1);
		t_trig(HHT_MODE_WMON, 1'b0, 1'b0, 0, 0, 0);
		t_trig(HHT_MODE_MMON, 1'b1, 1'b0, 0, 0, 0);
		do_reset(1'b1);
		t_zero_wait(1'b1);
		conclude();
	end
endmodule

`default_nettype wire
